// ==== hdl/redriver_ctl.v ====
// Purpose: Mode, gain and link-state control of a 2:1 USB 3.1 redriver switch.
// Assumes: Inputs synchronous to clk_i; four-level pins arrive pre-decoded.
// Notes: The rules that this block keeps are listed below.
// Functional notes
// - Nonzero mode strap selects register mode.
// - Control code 00 off, 01 on, others reserved.
// - Gain setting is four times high plus low.
// - Lane A, lane B, upstream selectors, pins or registers.
// - Enabled link sits in exactly one state.
// - Disconnect until both terminations, then U0.
// - U0 redrives traffic on both ports.
// - Idle on both ports moves U0 to U1.
// - U1 keeps terminations and common mode.
// - U2/U3 polls detection; missing termination disconnects.
// - U2/U3 signaling detected moves to U0.
// - U2/U3 keeps terminations, drops common mode.
// - Power good within 500 microseconds.
// - Debounce test, enable and orientation pins.
// - Straps latched once power good rises, pulls dropped.
// - Pin mode enable and orientation pins steer routing.
// - Equalization off while signaling is received.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "redriver_ctl_map.vh"

module redriver_ctl #(
	parameter [31:0] PG_CYCLES = `POWER_GOOD_DELAY_US * `CLK_MHZ,
	parameter [31:0] DB_CYCLES = `CONTROL_DEBOUNCE_TIME_US * `CLK_MHZ,
	parameter [31:0] DET_CYCLES = `DETECT_PERIOD_US * `CLK_MHZ
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire [31:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [1:0] config_mode_level_i,
	input wire [1:0] downstream_gain_pin_high_i,
	input wire [1:0] downstream_gain_pin_low_i,
	input wire [1:0] upstream_gain_pin_high_i,
	input wire [1:0] upstream_gain_pin_low_i,
	input wire usb_enable_pin_i,
	input wire orientation_pin_i,
	input wire test_strap_pin_i,
	input wire up_term_i,
	input wire down_term_i,
	input wire up_idle_i,
	input wire down_idle_i,
	input wire lfps_i,
	output reg power_good_o,
	output reg strap_pulls_on_o,
	output reg route_unflipped_o,
	output reg route_flipped_o,
	output reg redrive_on_o,
	output reg rx_term_on_o,
	output reg tx_cm_on_o,
	output reg detect_pulse_o,
	output reg eq_on_o,
	output reg [3:0] lane_a_gain_o,
	output reg [3:0] lane_b_gain_o,
	output reg [3:0] upstream_gain_o,
	output reg [3:0] link_state_o,
	output reg test_mode_o
);
	localparam [3:0] ST_DISC = 4'h1;
	localparam [3:0] ST_U0 = 4'h2;
	localparam [3:0] ST_U1 = 4'h4;
	localparam [3:0] ST_U23 = 4'h8;

	// ***************************************************************
	// Power-up sequencing and strap latching.
	// ***************************************************************
	localparam [31:0] HOLD_CYCLES = `STRAP_HOLD_TIME_US * `CLK_MHZ;
	reg [31:0] pg_cnt_r;
	reg [31:0] hold_cnt_r;
	reg pg_r;
	reg latched_r;
	reg reg_mode_r;
	reg [3:0] pin_gain_ds_r;
	reg [3:0] pin_gain_up_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			pg_cnt_r <= 32'h0;
			hold_cnt_r <= 32'h0;
			pg_r <= 1'b0;
			latched_r <= 1'b0;
			reg_mode_r <= 1'b0;
			pin_gain_ds_r <= `GAIN_RESET;
			pin_gain_up_r <= `GAIN_RESET;
			strap_pulls_on_o <= 1'b1;
			power_good_o <= 1'b0;
		end else if (ce_i) begin
			if (!pg_r) begin
				if (pg_cnt_r >= PG_CYCLES - 32'h1)
					pg_r <= 1'b1;
				else
					pg_cnt_r <= pg_cnt_r + 32'h1;
			end
			power_good_o <= pg_r;
			if (pg_r && !latched_r) begin
				latched_r <= 1'b1;
				reg_mode_r <= (config_mode_level_i != `LVL_0);
				pin_gain_ds_r <= {downstream_gain_pin_high_i, downstream_gain_pin_low_i};
				pin_gain_up_r <= {upstream_gain_pin_high_i, upstream_gain_pin_low_i};
			end
			if (latched_r && strap_pulls_on_o) begin
				if (hold_cnt_r >= HOLD_CYCLES - 32'h1)
					strap_pulls_on_o <= 1'b0;
				else
					hold_cnt_r <= hold_cnt_r + 32'h1;
			end
		end
	end

	// ***************************************************************
	// Control pin debounce.
	// ***************************************************************
	reg [2:0] db_stable_r;
	reg [2:0] db_last_r;
	reg [31:0] db_cnt_r;
	always @(posedge clk_i) begin
		if (rst_i) begin
			db_stable_r <= 3'h0;
			db_last_r <= 3'h0;
			db_cnt_r <= 32'h0;
		end else if (ce_i) begin
			db_last_r <= {test_strap_pin_i, orientation_pin_i, usb_enable_pin_i};
			if (db_last_r != {test_strap_pin_i, orientation_pin_i, usb_enable_pin_i})
				db_cnt_r <= 32'h0;
			else if (db_cnt_r >= DB_CYCLES - 32'h1)
				db_stable_r <= db_last_r;
			else
				db_cnt_r <= db_cnt_r + 32'h1;
		end
	end

	// ***************************************************************
	// Wishbone registers.
	// ***************************************************************
	reg [2:0] control_r;
	reg [3:0] lane_a_gain_select_r;
	reg [3:0] lane_b_gain_select_r;
	reg [3:0] upstream_gain_select_r;
	reg [15:0] idle_limit_r;
	wire control_code_high = control_r[`CTL_CODE_LSB + 1];
	wire control_code_low = control_r[`CTL_CODE_LSB];
	wire orientation_bit = control_r[`CTL_ORIENT_BIT];
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [7:0] ofs = wb_adr_i[7:0];
	reg [31:0] rd_nxt;
	always @* begin
		case (ofs)
		`OFS_CONTROL: rd_nxt = {29'h0, control_r};
		`OFS_GAIN_LANE_A: rd_nxt = {28'h0, lane_a_gain_select_r};
		`OFS_GAIN_LANE_B: rd_nxt = {28'h0, lane_b_gain_select_r};
		`OFS_GAIN_UP: rd_nxt = {28'h0, upstream_gain_select_r};
		`OFS_STATUS: rd_nxt = {24'h0, db_stable_r, reg_mode_r, link_state_o};
		`OFS_IDLE_LIMIT: rd_nxt = {16'h0, idle_limit_r};
		default: rd_nxt = 32'h0;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			control_r <= `CONTROL_RESET;
			lane_a_gain_select_r <= `GAIN_RESET;
			lane_b_gain_select_r <= `GAIN_RESET;
			upstream_gain_select_r <= `GAIN_RESET;
			idle_limit_r <= `IDLE_LIMIT_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else if (ce_i) begin
			wb_ack_o <= req;
			if (req) begin
				wb_dat_o <= rd_nxt;
				if (wb_we_i && wb_sel_i[0]) begin
					case (ofs)
					`OFS_CONTROL: control_r <= wb_dat_i[2:0];
					`OFS_GAIN_LANE_A: lane_a_gain_select_r <= wb_dat_i[3:0];
					`OFS_GAIN_LANE_B: lane_b_gain_select_r <= wb_dat_i[3:0];
					`OFS_GAIN_UP: upstream_gain_select_r <= wb_dat_i[3:0];
					`OFS_IDLE_LIMIT: idle_limit_r[7:0] <= wb_dat_i[7:0];
					default: ;
					endcase
				end
				if (wb_we_i && wb_sel_i[1] && ofs == `OFS_IDLE_LIMIT)
					idle_limit_r[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ***************************************************************
	// Mode decode.
	// ***************************************************************
	wire pin_on = db_stable_r[0];
	wire reg_on = !control_code_high && control_code_low;
	wire usb_on = latched_r && (reg_mode_r ? reg_on : pin_on);
	wire flip = reg_mode_r ? orientation_bit : db_stable_r[1];

	// ***************************************************************
	// Link-state machine.
	// ***************************************************************
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [15:0] idle_cnt_r;
	reg [31:0] det_cnt_r;
	wire both_term = up_term_i && down_term_i;
	wire both_idle = up_idle_i && down_idle_i;
	wire det_tick = (det_cnt_r >= DET_CYCLES - 32'h1);
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_DISC: if (both_term) state_nxt = ST_U0;
		ST_U0: if (both_idle) state_nxt = ST_U1;
		ST_U1: begin
			if (!both_idle || lfps_i)
				state_nxt = ST_U0;
			else if (idle_cnt_r >= idle_limit_r)
				state_nxt = ST_U23;
		end
		ST_U23: begin
			if (det_tick && !both_term)
				state_nxt = ST_DISC;
			else if (lfps_i)
				state_nxt = ST_U0;
		end
		default: state_nxt = ST_DISC;
		endcase
		if (!usb_on)
			state_nxt = ST_DISC;
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_DISC;
			idle_cnt_r <= 16'h0;
			det_cnt_r <= 32'h0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			if (state_r == ST_U1 && state_nxt == ST_U1)
				idle_cnt_r <= idle_cnt_r + 16'h1;
			else
				idle_cnt_r <= 16'h0;
			if (state_r != ST_U23 || det_tick)
				det_cnt_r <= 32'h0;
			else
				det_cnt_r <= det_cnt_r + 32'h1;
		end
	end

	// ***************************************************************
	// Registered outputs.
	// ***************************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			route_unflipped_o <= 1'b0;
			route_flipped_o <= 1'b0;
			redrive_on_o <= 1'b0;
			rx_term_on_o <= 1'b0;
			tx_cm_on_o <= 1'b0;
			detect_pulse_o <= 1'b0;
			eq_on_o <= 1'b0;
			lane_a_gain_o <= `GAIN_RESET;
			lane_b_gain_o <= `GAIN_RESET;
			upstream_gain_o <= `GAIN_RESET;
			link_state_o <= ST_DISC;
			test_mode_o <= 1'b0;
		end else if (ce_i) begin
			route_unflipped_o <= usb_on && !flip;
			route_flipped_o <= usb_on && flip;
			redrive_on_o <= (state_nxt == ST_U0);
			rx_term_on_o <= (state_nxt != ST_DISC);
			tx_cm_on_o <= (state_nxt == ST_U0) || (state_nxt == ST_U1);
			detect_pulse_o <= (state_r == ST_U23 && det_tick) || (state_r == ST_DISC && usb_on);
			eq_on_o <= usb_on && !lfps_i;
			lane_a_gain_o <= reg_mode_r ? lane_a_gain_select_r : pin_gain_ds_r;
			lane_b_gain_o <= reg_mode_r ? lane_b_gain_select_r : pin_gain_ds_r;
			upstream_gain_o <= reg_mode_r ? upstream_gain_select_r : pin_gain_up_r;
			link_state_o <= state_nxt;
			test_mode_o <= db_stable_r[2];
		end
	end
endmodule // redriver_ctl

// ==== hdl/redriver_ctl_map.vh ====
// Purpose: Constants for the redriver mode control block.
// Assumes: 125 MHz clock, Wishbone register bus with 32-bit data.
// Notes: Offsets are byte addresses; times are in microseconds.
`ifndef REDRIVER_CTL_MAP_VH
`define REDRIVER_CTL_MAP_VH
`define CLK_MHZ 125
`define OFS_CONTROL 8'h00
`define OFS_GAIN_LANE_A 8'h04
`define OFS_GAIN_LANE_B 8'h08
`define OFS_GAIN_UP 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IDLE_LIMIT 8'h14
`define CTL_ORIENT_BIT 2
`define CTL_CODE_LSB 0
`define CONTROL_RESET 3'h1
`define GAIN_RESET 4'h0
`define IDLE_LIMIT_RESET 16'h0400
`define POWER_GOOD_DELAY_US 500
`define STRAP_SETUP_TIME_US 250
`define STRAP_HOLD_TIME_US 10
`define CONTROL_DEBOUNCE_TIME_US 16000
`define DETECT_PERIOD_US 100
`define LVL_0 2'h0
`define LVL_R 2'h1
`define LVL_F 2'h2
`define LVL_1 2'h3
`endif

// ==== verification/link_far_end.sv ====
// Purpose: Far-end link partner giving termination, idle and signaling.
// Assumes: mode_i changes right after a clock edge.
// Notes: Mode 0 detached, 1 traffic, 2 idle, 3 signaling burst.
`timescale 1ns/1ps
module link_far_end (
	input wire clk_i,
	input wire [1:0] mode_i,
	output reg up_term_o,
	output reg down_term_o,
	output reg up_idle_o,
	output reg down_idle_o,
	output reg lfps_o
);
	always @(posedge clk_i) begin
		up_term_o <= mode_i != 2'h0;
		down_term_o <= mode_i != 2'h0;
		up_idle_o <= !mode_i[0];
		down_idle_o <= !mode_i[0];
		lfps_o <= mode_i == 2'h3;
	end
endmodule // link_far_end

// ==== verification/redriver_ctl_bench.sv ====
// Purpose: Self-checking bench for redriver_ctl.
// Assumes: Shortened power-good, debounce and detect counts.
// Notes: Pin mode first, then register mode after a second reset.
`timescale 1ns/1ps
module redriver_ctl_bench;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, en = 1'h0, ori = 1'h0, tst = 1'h0;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0, q, rd;
	logic [1:0] cfg = 2'h0, mode = 2'h0;
	logic [1:0] gdh = 2'h1, gdl = 2'h2, guh = 2'h3, gul = 2'h0;
	logic pg, dp, tm, seen_det = 1'h0;
	logic ack, ut, dt, ui, di, lf, pulls, ru, rf, rdv, rt, cm, eqo;
	logic [3:0] ga, gb, gu, ls;
	int error_cnt = 0, comparisons = 0;
	always #4 clk_i = ~clk_i;
	// ****************************************
	// Design, far end and bus tasks.
	// ****************************************
	redriver_ctl #(.PG_CYCLES(32'hA), .DB_CYCLES(32'h4), .DET_CYCLES(32'h8)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_adr_i({24'h0, adr}), .wb_dat_i(dat),
		.wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(q),
		.wb_ack_o(ack), .config_mode_level_i(cfg), .downstream_gain_pin_high_i(gdh),
		.downstream_gain_pin_low_i(gdl), .upstream_gain_pin_high_i(guh),
		.upstream_gain_pin_low_i(gul), .usb_enable_pin_i(en), .orientation_pin_i(ori),
		.test_strap_pin_i(tst), .up_term_i(ut), .down_term_i(dt), .up_idle_i(ui),
		.down_idle_i(di), .lfps_i(lf), .power_good_o(pg), .strap_pulls_on_o(pulls),
		.route_unflipped_o(ru), .route_flipped_o(rf), .redrive_on_o(rdv), .rx_term_on_o(rt),
		.tx_cm_on_o(cm), .detect_pulse_o(dp), .eq_on_o(eqo), .lane_a_gain_o(ga),
		.lane_b_gain_o(gb), .upstream_gain_o(gu), .link_state_o(ls), .test_mode_o(tm));
	always @(posedge clk_i) if (dp) seen_det <= 1'h1;
	link_far_end far (.clk_i(clk_i), .mode_i(mode), .up_term_o(ut), .down_term_o(dt),
		.up_idle_o(ui), .down_idle_o(di), .lfps_o(lf));
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			results;
		end
		rd = q;
		cyc <= 1'h0;
		we <= 1'h0;
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ****************************************
	// Tests.
	// ****************************************
	initial begin
		tick(30000);
		error_cnt++;
		results;
	end
	initial begin
		tick(4);
		rst_i <= 1'h0;
		en <= 1'h1;
		tick(30);
		chk("pulls", pulls, 1'h1);
		chk("power good", pg, 1'h1);
		chk("gains", {ga, gb, gu}, 12'h66C);
		chk("route", {ru, rf}, 2'h2);
		ori <= 1'h1;
		tick(10);
		chk("flip", {ru, rf}, 2'h1);
		mode <= 2'h1;
		tick(4);
		chk("attach", {rdv, ls}, 5'h12);
		mode <= 2'h2;
		tick(4);
		chk("u1", {rt, cm, ls}, 6'h34);
		mode <= 2'h1;
		tick(4);
		chk("wake", ls, 4'h2);
		mode <= 2'h2;
		tick(1100);
		chk("u23", {rt, cm, ls}, 6'h28);
		mode <= 2'h3;
		tick(4);
		chk("lfps", {eqo, ls}, 5'h2);
		mode <= 2'h2;
		tick(1100);
		mode <= 2'h0;
		tick(20);
		chk("detach", {pulls, ls}, 5'h1);
		chk("detect", seen_det, 1'h1);
		en <= 1'h0;
		mode <= 2'h1;
		tick(10);
		chk("off", {ru, rf, ls}, 6'h1);
		$display("pin mode test done");
		rst_i <= 1'h1;
		cfg <= 2'h1;
		gdh <= 2'h3;
		gdl <= 2'h3;
		guh <= 2'h0;
		gul <= 2'h1;
		tick(4);
		rst_i <= 1'h0;
		tick(30);
		bus(1'h0, 8'h00, 32'h0);
		chk("ctl reset", rd, 32'h1);
		for (int c = 0; c < 8; c++) begin
			bus(1'h1, 8'h00, c);
			tick(3);
			chk("code", {ru, rf}, c[1:0] == 2'h1 ? {~c[2], c[2]} : 2'h0);
		end
		bus(1'h1, 8'h14, 32'h5);
		bus(1'h1, 8'h00, 32'h1);
		tick(4);
		bus(1'h0, 8'h10, 32'h0);
		chk("status", rd[4:0], 5'h12);
		mode <= 2'h2;
		tick(20);
		chk("timeout", ls, 4'h8);
		bus(1'h1, 8'h04, 32'h9);
		bus(1'h1, 8'h08, 32'h3);
		bus(1'h1, 8'h0C, 32'hF);
		bus(1'h0, 8'h04, 32'h0);
		chk("gain rd", rd, 32'h9);
		chk("gain regs", {ga, gb, gu}, 12'h93F);
		bus(1'h0, 8'h18, 32'h0);
		chk("unmapped", rd, 32'h0);
		tst <= 1'h1;
		tick(10);
		bus(1'h0, 8'h10, 32'h0);
		chk("test pin", rd[7], 1'h1);
		chk("test mode", tm, 1'h1);
		$display("register mode test done");
		results;
	end
endmodule // redriver_ctl_bench

// ==== verification/redriver_ctl_props.sv ====
// Purpose: Concurrent checks on the redriver control ports.
// Assumes: ce_i stays high; link state one-hot 1 Disc, 2 U0, 4 U1, 8 U2/U3.
// Notes: Attached by bind after the module.
`timescale 1ns/1ps
module redriver_ctl_props (
	input wire clk_i,
	input wire rst_i,
	input wire wb_ack_o,
	input wire up_term_i,
	input wire down_term_i,
	input wire up_idle_i,
	input wire down_idle_i,
	input wire lfps_i,
	input wire power_good_o,
	input wire route_unflipped_o,
	input wire route_flipped_o,
	input wire rx_term_on_o,
	input wire tx_cm_on_o,
	input wire eq_on_o,
	input wire [3:0] link_state_o
);
	wire route_on = route_unflipped_o | route_flipped_o;
	wire both_term = up_term_i & down_term_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	one_state_a: assert property ($onehot(link_state_o)) else $error("state not one-hot");
	disc_exit_a: assert property (link_state_o == 4'h1 && both_term && route_on
		|=> link_state_o == 4'h2 || !route_on) else $error("no U0 on attach");
	u1_entry_a: assert property (link_state_o == 4'h2 && up_idle_i && down_idle_i
		|=> link_state_o == 4'h4 || !route_on) else $error("no U1 on idle");
	u0_wake_a: assert property (link_state_o == 4'h8 && lfps_i && both_term
		|=> link_state_o == 4'h2 || !route_on) else $error("no wake on signaling");
	u1_power_a: assert property (link_state_o == 4'h4 [*2] |-> rx_term_on_o && tx_cm_on_o)
		else $error("U1 power wrong");
	u23_power_a: assert property (link_state_o == 4'h8 [*2] |-> rx_term_on_o && !tx_cm_on_o)
		else $error("U2/U3 power wrong");
	off_disc_a: assert property (!route_on [*2] |-> link_state_o == 4'h1)
		else $error("state while off");
	lfps_eq_a: assert property (lfps_i [*2] |-> !eq_on_o) else $error("eq on in signaling");
	pg_time_a: assert property ($fell(rst_i) |-> ##[0:12] power_good_o) else $error("late pg");
endmodule // redriver_ctl_props
bind redriver_ctl redriver_ctl_props chk (.*);
